// ---- logic/sdw_defines.svh ----
// Offsets, field positions, reset values and fixed attributes of the writer
`ifndef SDW_DEFINES_SVH
`define SDW_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SDW_OFF_NEXT_LO 8'h00
`define SDW_OFF_NEXT_HI 8'h04
`define SDW_OFF_BUF_LO 8'h08
`define SDW_OFF_BUF_HI 8'h0c
`define SDW_OFF_ATTR 8'h10
`define SDW_OFF_STRIDE 8'h14
`define SDW_OFF_HSIZE 8'h18
`define SDW_OFF_STATUS 8'h1c
`define SDW_OFF_PTR_LO 8'h20
`define SDW_OFF_PTR_HI 8'h24
`define SDW_OFF_CTRL 8'h28

// ----------------------------------------------------------------
// Descriptor fields
// ----------------------------------------------------------------
`define SDW_NEXT_PTR_HI 31
`define SDW_NEXT_PTR_LO 6
`define SDW_CACHE_HI 27
`define SDW_CACHE_LO 24
`define SDW_USER_HI 31
`define SDW_USER_LO 28
`define SDW_STRIDE_HI 15
`define SDW_STRIDE_LO 0
`define SDW_LINES_HI 31
`define SDW_LINES_LO 19
`define SDW_HSIZE_HI 15
`define SDW_HSIZE_LO 0

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define SDW_ST_CMP 31
`define SDW_ST_SE 29
`define SDW_ST_IE 28
`define SDW_ST_SOP 27
`define SDW_ST_EOP 26
`define SDW_ST_TUSER_HI 19
`define SDW_ST_TUSER_LO 16
`define SDW_ST_TID_HI 12
`define SDW_ST_TID_LO 8
`define SDW_ST_TDEST_HI 4
`define SDW_ST_TDEST_LO 0

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define SDW_CTRL_START 0
`define SDW_CTRL_WIDE 1
`define SDW_CTRL_CLEAR 2

// ----------------------------------------------------------------
// Reset values and write attributes
// ----------------------------------------------------------------
`define SDW_ATTR_RESET 32'h03000000
`define SDW_BEAT_BYTES 16'h0004
`define SDW_AWSIZE 3'h2
`define SDW_AWBURST 2'h1
`define SDW_AWLEN 8'h00
`define SDW_BRESP_SLVERR 2'h2
`define SDW_BUF_DEPTH 2'h2

`endif

// ---- logic/sdw_pkg.sv ----
// Types shared by the stride writer
package sdw_pkg;

  typedef enum logic [2:0]
  {
    SDW_IDLE = 3'b000,
    SDW_WAIT_DATA = 3'b001,
    SDW_ISSUE = 3'b010,
    SDW_RESP = 3'b011,
    SDW_DONE = 3'b100,
    SDW_HALT = 3'b101
  } sdw_state_t;

endpackage

// ---- logic/sdw_writer.sv ----
// Receive-path descriptor engine writing one stream packet as strided lines
//
// Overview of operation
// (R1) Next pointer uses bits 31:6; low six bits forced to zero.
// (R2) In wide mode upper next-pointer word forms pointer bits 63:32.
// (R3) Software aligns the lower buffer address to the data bus width.
// (R4) Upper buffer word drives address bits 63:32 only in wide mode.
// (R5) Cache field bits 27:24 drive the write cache attribute on every address phase.
// (R6) Software should program the cache field to binary 0011.
// (R7) User field bits 31:28 drive the write user sideband, uninterpreted.
// (R8) Software may repeat the user field in every chained descriptor.
// (R9) Stride bits 15:0 give byte distance between successive line starts.
// (R10) Each line writes line-length consecutive bytes, then skips to next stride.
// (R11) Lines repeat until the line count is reached, then descriptor completes.
// (R12) Line count sits in bits 31:19; bits 18:16 are reserved.
// (R13) Source sends all lines as one packet with a single final TLAST.
// (R14) Reserved descriptor bits are written zero and ignored by the engine.
// (R15) Line length in bits 15:0 of the word at offset 18h.
// (R16) Packet TDEST, TID, TUSER are captured into status bits 4:0, 12:8, 19:16.
// (R17) Start and end of packet flags set in status bits 27 and 26.
// (R18) Under/over-run sets bit 28 and halts; slave error sets bit 29 and halts.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sdw_defines.svh"

module sdw_writer
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_rx_stream_port_tvalid,
  input wire logic [31:0] i_rx_stream_port_tdata,
  input wire logic i_rx_stream_port_tlast,
  input wire logic [4:0] i_rx_stream_port_tdest,
  input wire logic [4:0] i_rx_stream_port_tid,
  input wire logic [3:0] i_rx_stream_port_tuser,
  output logic o_rx_stream_port_tready,
  output logic [63:0] o_awaddr,
  output logic [7:0] o_awlen,
  output logic [2:0] o_awsize,
  output logic [1:0] o_awburst,
  output logic [3:0] o_awcache,
  output logic [3:0] o_awuser,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wlast,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  output logic o_bready,
  output logic o_busy,
  output logic [63:0] o_next_desc_addr
);

  // ----------------------------------------------------------------
  // Descriptor and control registers
  // ----------------------------------------------------------------
  logic [31:0] next_desc_ptr_lo_q;
  logic [31:0] next_desc_ptr_hi_q;
  logic [31:0] buf_addr_lo_q;
  logic [31:0] buf_addr_hi_q;
  logic [31:0] write_attr_word_q;
  logic [31:0] stride_linecount_word_q;
  logic [31:0] line_len_word_q;
  logic [31:0] rx_completion_status_q;
  logic wide_q;
  logic start_pulse;
  logic clear_pulse;
  logic [63:0] next_ptr;

  assign start_pulse = i_reg_wr && (i_reg_addr == `SDW_OFF_CTRL) &&
                       i_reg_wdata[`SDW_CTRL_START];
  assign clear_pulse = i_reg_wr && (i_reg_addr == `SDW_OFF_CTRL) &&
                       i_reg_wdata[`SDW_CTRL_CLEAR];

  // Reserved bits never stored, so they can never steer the engine
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      next_desc_ptr_lo_q <= 32'h0;
      next_desc_ptr_hi_q <= 32'h0;
      buf_addr_lo_q <= 32'h0;
      buf_addr_hi_q <= 32'h0;
      write_attr_word_q <= `SDW_ATTR_RESET;
      stride_linecount_word_q <= 32'h0;
      line_len_word_q <= 32'h0;
      wide_q <= 1'b0;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        `SDW_OFF_NEXT_LO:
          next_desc_ptr_lo_q <= {i_reg_wdata[31:6], 6'h0}; // (R1) (R14)
        `SDW_OFF_NEXT_HI:
          next_desc_ptr_hi_q <= i_reg_wdata;
        `SDW_OFF_BUF_LO:
          buf_addr_lo_q <= i_reg_wdata;
        `SDW_OFF_BUF_HI:
          buf_addr_hi_q <= i_reg_wdata;
        `SDW_OFF_ATTR:
          write_attr_word_q <= {i_reg_wdata[31:24], 24'h0}; // (R14)
        `SDW_OFF_STRIDE:
          stride_linecount_word_q <= {i_reg_wdata[31:19], 3'h0, i_reg_wdata[15:0]}; // (R12) (R14)
        `SDW_OFF_HSIZE:
          line_len_word_q <= {16'h0, i_reg_wdata[15:0]}; // (R15) (R14)
        `SDW_OFF_CTRL:
          wide_q <= i_reg_wdata[`SDW_CTRL_WIDE];
        default:
          wide_q <= wide_q;
      endcase
    end
  end

  // Next pointer: low bits zero, upper half only in wide mode
  assign next_ptr = {wide_q ? next_desc_ptr_hi_q : 32'h0, // (R2)
                     next_desc_ptr_lo_q[`SDW_NEXT_PTR_HI:`SDW_NEXT_PTR_LO], 6'h0}; // (R1)

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_next_desc_addr <= 64'h0;
    else
      o_next_desc_addr <= next_ptr;
  end

  // ----------------------------------------------------------------
  // Two-entry stream buffer
  // ----------------------------------------------------------------
  logic [46:0] buf_mem_q [0:1];
  logic buf_wr_ptr_q;
  logic buf_rd_ptr_q;
  logic [1:0] buf_count_q;
  logic [1:0] buf_count_d;
  logic buf_push;
  logic buf_pop;
  logic buf_valid;
  logic [46:0] buf_head;

  // Ready is registered, so full is judged on next count
  assign buf_push = i_rx_stream_port_tvalid && o_rx_stream_port_tready;
  assign buf_valid = (buf_count_q != 2'h0);
  assign buf_head = buf_mem_q[buf_rd_ptr_q];

  always_comb
  begin
    buf_count_d = buf_count_q;
    if (buf_push && !buf_pop)
      buf_count_d = buf_count_q + 2'h1;
    else if (!buf_push && buf_pop)
      buf_count_d = buf_count_q - 2'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      buf_wr_ptr_q <= 1'b0;
      buf_rd_ptr_q <= 1'b0;
      buf_count_q <= 2'h0;
      o_rx_stream_port_tready <= 1'b0;
      buf_mem_q[0] <= 47'h0;
      buf_mem_q[1] <= 47'h0;
    end
    else
    begin
      if (buf_push)
      begin
        buf_mem_q[buf_wr_ptr_q] <= {i_rx_stream_port_tuser, i_rx_stream_port_tid,
                                    i_rx_stream_port_tdest, i_rx_stream_port_tlast,
                                    i_rx_stream_port_tdata};
        buf_wr_ptr_q <= ~buf_wr_ptr_q;
      end
      if (buf_pop)
        buf_rd_ptr_q <= ~buf_rd_ptr_q;
      buf_count_q <= buf_count_d;
      o_rx_stream_port_tready <= (buf_count_d != `SDW_BUF_DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------
  sdw_pkg::sdw_state_t state_q;
  logic [63:0] line_base_q;
  logic [15:0] bytes_left_q;
  logic [12:0] lines_left_q;
  logic beat_last_q;
  logic aw_done_q;
  logic w_done_q;
  logic first_beat_q;
  logic [63:0] start_addr;
  logic [15:0] stride;
  logic [15:0] line_len;
  logic [12:0] line_count;
  logic line_end;
  logic final_beat;

  assign stride = stride_linecount_word_q[`SDW_STRIDE_HI:`SDW_STRIDE_LO]; // (R9)
  assign line_count = stride_linecount_word_q[`SDW_LINES_HI:`SDW_LINES_LO]; // (R12)
  assign line_len = line_len_word_q[`SDW_HSIZE_HI:`SDW_HSIZE_LO]; // (R15)
  assign start_addr = {wide_q ? buf_addr_hi_q : 32'h0, buf_addr_lo_q}; // (R4)
  assign line_end = (bytes_left_q <= `SDW_BEAT_BYTES);
  assign final_beat = line_end && (lines_left_q == 13'h1); // (R11)
  assign buf_pop = (state_q == sdw_pkg::SDW_WAIT_DATA) && buf_valid;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_q <= sdw_pkg::SDW_IDLE;
      line_base_q <= 64'h0;
      o_awaddr <= 64'h0;
      bytes_left_q <= 16'h0;
      lines_left_q <= 13'h0;
      first_beat_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        sdw_pkg::SDW_IDLE, sdw_pkg::SDW_DONE:
          if (start_pulse)
          begin
            line_base_q <= start_addr;
            o_awaddr <= start_addr; // (R10)
            bytes_left_q <= line_len;
            lines_left_q <= line_count;
            first_beat_q <= 1'b1;
            // Zero line count or length can never match a packet
            if (line_count == 13'h0 || line_len == 16'h0)
              state_q <= sdw_pkg::SDW_HALT; // (R18)
            else
              state_q <= sdw_pkg::SDW_WAIT_DATA;
          end
        sdw_pkg::SDW_WAIT_DATA:
          if (buf_valid)
            state_q <= sdw_pkg::SDW_ISSUE;
        sdw_pkg::SDW_ISSUE:
          if ((aw_done_q || i_awready) && (w_done_q || i_wready))
            state_q <= sdw_pkg::SDW_RESP;
        sdw_pkg::SDW_RESP:
          if (i_bvalid)
          begin
            first_beat_q <= 1'b0;
            if (i_bresp == `SDW_BRESP_SLVERR)
              state_q <= sdw_pkg::SDW_HALT; // (R18)
            else if (beat_last_q != final_beat)
              state_q <= sdw_pkg::SDW_HALT; // (R13) (R18)
            else if (final_beat)
              state_q <= sdw_pkg::SDW_DONE; // (R11)
            else if (line_end)
            begin
              // Next line starts one stride past the previous start
              line_base_q <= line_base_q + {48'h0, stride}; // (R10)
              o_awaddr <= line_base_q + {48'h0, stride}; // (R9)
              bytes_left_q <= line_len;
              lines_left_q <= lines_left_q - 13'h1; // (R11)
              state_q <= sdw_pkg::SDW_WAIT_DATA;
            end
            else
            begin
              o_awaddr <= o_awaddr + 64'h4; // (R10)
              bytes_left_q <= bytes_left_q - `SDW_BEAT_BYTES;
              state_q <= sdw_pkg::SDW_WAIT_DATA;
            end
          end
        sdw_pkg::SDW_HALT:
          if (clear_pulse)
            state_q <= sdw_pkg::SDW_IDLE;
        default:
          state_q <= sdw_pkg::SDW_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  // Single-beat bursts keep line ends and strides trivially exact
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_awvalid <= 1'b0;
      o_wvalid <= 1'b0;
      o_bready <= 1'b0;
      o_wdata <= 32'h0;
      o_wstrb <= 4'h0;
      o_wlast <= 1'b0;
      o_awcache <= 4'h0;
      o_awuser <= 4'h0;
      beat_last_q <= 1'b0;
      aw_done_q <= 1'b0;
      w_done_q <= 1'b0;
    end
    else
    begin
      if (buf_pop)
      begin
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        o_wlast <= 1'b1;
        o_wdata <= buf_head[31:0];
        beat_last_q <= buf_head[32];
        aw_done_q <= 1'b0;
        w_done_q <= 1'b0;
        o_awcache <= write_attr_word_q[`SDW_CACHE_HI:`SDW_CACHE_LO]; // (R5)
        o_awuser <= write_attr_word_q[`SDW_USER_HI:`SDW_USER_LO]; // (R7)
        case (bytes_left_q)
          16'h1: o_wstrb <= 4'h1;
          16'h2: o_wstrb <= 4'h3;
          16'h3: o_wstrb <= 4'h7;
          default: o_wstrb <= 4'hf;
        endcase
      end
      else if (state_q == sdw_pkg::SDW_ISSUE)
      begin
        if (i_awready)
        begin
          o_awvalid <= 1'b0;
          aw_done_q <= 1'b1;
        end
        if (i_wready)
        begin
          o_wvalid <= 1'b0;
          w_done_q <= 1'b1;
        end
        if ((aw_done_q || i_awready) && (w_done_q || i_wready))
          o_bready <= 1'b1;
      end
      else if (state_q == sdw_pkg::SDW_RESP && i_bvalid)
        o_bready <= 1'b0;
    end
  end

  assign o_awlen = `SDW_AWLEN;
  assign o_awsize = `SDW_AWSIZE;
  assign o_awburst = `SDW_AWBURST;

  // ----------------------------------------------------------------
  // Completion status
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      rx_completion_status_q <= 32'h0;
    else if (start_pulse && (state_q == sdw_pkg::SDW_IDLE || state_q == sdw_pkg::SDW_DONE))
    begin
      rx_completion_status_q <= 32'h0;
      if (line_count == 13'h0 || line_len == 16'h0)
        rx_completion_status_q[`SDW_ST_IE] <= 1'b1; // (R18)
    end
    else if (buf_pop && first_beat_q)
    begin
      rx_completion_status_q[`SDW_ST_TDEST_HI:`SDW_ST_TDEST_LO] <= buf_head[37:33]; // (R16)
      rx_completion_status_q[`SDW_ST_TID_HI:`SDW_ST_TID_LO] <= buf_head[42:38]; // (R16)
      rx_completion_status_q[`SDW_ST_TUSER_HI:`SDW_ST_TUSER_LO] <= buf_head[46:43]; // (R16)
      rx_completion_status_q[`SDW_ST_SOP] <= 1'b1; // (R17)
    end
    else if (state_q == sdw_pkg::SDW_RESP && i_bvalid)
    begin
      if (i_bresp == `SDW_BRESP_SLVERR)
        rx_completion_status_q[`SDW_ST_SE] <= 1'b1; // (R18)
      else if (beat_last_q != final_beat)
        rx_completion_status_q[`SDW_ST_IE] <= 1'b1; // (R18)
      else if (final_beat)
      begin
        rx_completion_status_q[`SDW_ST_EOP] <= 1'b1; // (R17)
        rx_completion_status_q[`SDW_ST_CMP] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_busy <= 1'b0;
    else
      o_busy <= (state_q == sdw_pkg::SDW_WAIT_DATA) || (state_q == sdw_pkg::SDW_ISSUE) ||
                (state_q == sdw_pkg::SDW_RESP);
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_reg_rdata <= 32'h0;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        `SDW_OFF_NEXT_LO: o_reg_rdata <= next_desc_ptr_lo_q;
        `SDW_OFF_NEXT_HI: o_reg_rdata <= next_desc_ptr_hi_q;
        `SDW_OFF_BUF_LO: o_reg_rdata <= buf_addr_lo_q;
        `SDW_OFF_BUF_HI: o_reg_rdata <= buf_addr_hi_q;
        `SDW_OFF_ATTR: o_reg_rdata <= write_attr_word_q;
        `SDW_OFF_STRIDE: o_reg_rdata <= stride_linecount_word_q;
        `SDW_OFF_HSIZE: o_reg_rdata <= line_len_word_q;
        `SDW_OFF_STATUS: o_reg_rdata <= rx_completion_status_q;
        `SDW_OFF_PTR_LO: o_reg_rdata <= next_ptr[31:0];
        `SDW_OFF_PTR_HI: o_reg_rdata <= next_ptr[63:32];
        `SDW_OFF_CTRL: o_reg_rdata <= {29'h0, state_q == sdw_pkg::SDW_HALT, wide_q, o_busy};
        default: o_reg_rdata <= 32'h0;
      endcase
    end
    else
      o_reg_rdata <= 32'h0;
  end

endmodule

`default_nettype wire

// ---- tb/sdw_writer_assertions.sv ----
// Concurrent checks on the stride writer's memory-side ports
`timescale 1ns/100ps
`default_nettype none

module sdw_writer_chk
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [63:0] o_awaddr,
  input wire logic [7:0] o_awlen,
  input wire logic [2:0] o_awsize,
  input wire logic [1:0] o_awburst,
  input wire logic [3:0] o_awcache,
  input wire logic [3:0] o_awuser,
  input wire logic o_awvalid,
  input wire logic i_awready,
  input wire logic [31:0] o_wdata,
  input wire logic [3:0] o_wstrb,
  input wire logic o_wlast,
  input wire logic o_wvalid,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  input wire logic o_bready
);
  // ------------------------------
  // Write channel checks
  // ------------------------------
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_beat_shape:
    assert property (o_awvalid |-> o_awlen == 8'h00 && o_awsize == 3'h2 && o_awburst == 2'h1)
    else $error("write address shape wrong");
  a_aw_held:
    assert property (o_awvalid && !i_awready |=> o_awvalid && $stable(o_awaddr)
      && $stable(o_awcache) && $stable(o_awuser)) else $error("address phase dropped");
  a_w_held:
    assert property (o_wvalid && !i_wready |=> o_wvalid && $stable(o_wdata) && $stable(o_wstrb))
    else $error("data phase dropped");
  a_aw_with_w:
    assert property ($rose(o_awvalid) |-> $rose(o_wvalid)) else $error("address without data");
  a_addr_words:
    assert property (o_awvalid |-> o_awaddr[1:0] == 2'h0) else $error("unaligned write");
  a_strb_low:
    assert property (o_wvalid |-> o_wlast && o_wstrb inside {4'h1, 4'h3, 4'h7, 4'hf})
    else $error("byte strobes not low aligned");
  a_one_write:
    assert property (o_bready |-> !o_awvalid && !o_wvalid) else $error("overlapping writes");
  a_bready_drop:
    assert property (o_bready && i_bvalid |=> !o_bready) else $error("response wait stuck");
  a_slverr_halt:
    assert property (o_bready && i_bvalid && i_bresp == 2'h2 |=> !o_awvalid [*8])
    else $error("writes after slave error");
endmodule

bind sdw_writer sdw_writer_chk chk_u
(
  .i_clk(i_clk), .i_srst(i_srst), .o_awaddr(o_awaddr), .o_awlen(o_awlen),
  .o_awsize(o_awsize), .o_awburst(o_awburst), .o_awcache(o_awcache), .o_awuser(o_awuser),
  .o_awvalid(o_awvalid), .i_awready(i_awready), .o_wdata(o_wdata), .o_wstrb(o_wstrb),
  .o_wlast(o_wlast), .o_wvalid(o_wvalid), .i_wready(i_wready), .i_bresp(i_bresp),
  .i_bvalid(i_bvalid), .o_bready(o_bready)
);

`default_nettype wire

// ---- tb/sdw_mem_model.sv ----
// Memory-side responder for the writer's single-beat writes
`timescale 1ns/100ps
`default_nettype none

module sdw_mem_model
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_slow,
  input wire logic i_err,
  input wire logic i_awvalid,
  input wire logic i_wvalid,
  input wire logic i_bready,
  output logic o_awready,
  output logic o_wready,
  output logic o_bvalid,
  output logic [1:0] o_bresp
);
  logic aw_got_q, w_got_q;
  logic [1:0] pace_q, resp_q;

  // ------------------------------
  // Address and data taken apart
  // ------------------------------
  // Slow mode stalls long enough for the stream buffer to fill
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      pace_q <= 2'h0;
      resp_q <= 2'h0;
    end
    else
    begin
      pace_q <= pace_q + 2'h1;
      o_awready <= i_awvalid && !aw_got_q && !o_awready && (!i_slow || pace_q == 2'h3);
      o_wready <= i_wvalid && !w_got_q && !o_wready && (!i_slow || pace_q == 2'h1);
      if (i_awvalid && o_awready) aw_got_q <= 1'b1;
      if (i_wvalid && o_wready) w_got_q <= 1'b1;
      if (aw_got_q && w_got_q && !o_bvalid)
      begin
        o_bvalid <= 1'b1;
        resp_q <= i_err ? 2'h2 : 2'h0;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // Released response shows no stale code
  assign o_bresp = o_bvalid ? resp_q : ~resp_q;
endmodule

`default_nettype wire

// ---- tb/sdw_writer_tb.sv ----
// Self-checking bench for the stride writer
`timescale 1ns/100ps
`default_nettype none

module sdw_writer_tb;
  logic clk, srst, wr, rd, tv, tl, slow, err, trdy, busy;
  logic awvalid, awready, wlast, wvalid, wready, bvalid, bready;
  logic [7:0] ra, awlen;
  logic [31:0] wd, rdata, td, wdata;
  logic [4:0] tdst, tid;
  logic [3:0] tus, awcache, awuser, wstrb;
  logic [63:0] awaddr, nda;
  logic [2:0] awsize;
  logic [1:0] awburst, bresp;
  logic [63:0] aq[$];
  logic [31:0] dq[$];
  logic [3:0] sq[$], cq[$], uq[$];
  int n_errors = 0;
  int checks_done = 0;
  int stalls = 0;

  sdw_writer dut_u
  (
    .i_clk(clk), .i_srst(srst), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_rx_stream_port_tvalid(tv),
    .i_rx_stream_port_tdata(td), .i_rx_stream_port_tlast(tl),
    .i_rx_stream_port_tdest(tdst), .i_rx_stream_port_tid(tid),
    .i_rx_stream_port_tuser(tus), .o_rx_stream_port_tready(trdy),
    .o_awaddr(awaddr), .o_awlen(awlen), .o_awsize(awsize), .o_awburst(awburst),
    .o_awcache(awcache), .o_awuser(awuser), .o_awvalid(awvalid), .i_awready(awready),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_wlast(wlast), .o_wvalid(wvalid),
    .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
    .o_busy(busy), .o_next_desc_addr(nda)
  );

  sdw_mem_model mem_u
  (
    .i_clk(clk), .i_srst(srst), .i_slow(slow), .i_err(err), .i_awvalid(awvalid),
    .i_wvalid(wvalid), .i_bready(bready), .o_awready(awready), .o_wready(wready),
    .o_bvalid(bvalid), .o_bresp(bresp)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ------------------------------
  // Write log
  // ------------------------------
  always @(posedge clk)
  begin
    if (awvalid && awready)
    begin
      aq.push_back(awaddr);
      cq.push_back(awcache);
      uq.push_back(awuser);
    end
    if (wvalid && wready)
    begin
      dq.push_back(wdata);
      sq.push_back(wstrb);
    end
    if (tv && !trdy) stalls++;
  end

  // ------------------------------
  // Bus and compare tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Strobe stays up across back-to-back writes; the next task lowers it
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    wr <= 1'b0;
    rd <= 1'b1;
    ra <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(nm, {32'h0, e}, {32'h0, rdata & m});
  endtask

  task automatic send(input int n, input int last_at);
    wr <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      tv <= 1'b1;
      td <= 32'hc0de0000 + i;
      tl <= (i == last_at);
      @(posedge clk);
      while (trdy !== 1'b1) @(posedge clk);
    end
    tv <= 1'b0;
    tl <= 1'b0;
    td <= ~td;
  endtask

  task automatic wait_idle();
    wr <= 1'b0;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 500 && busy !== 1'b0; k++) @(posedge clk);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs();
    rchk("attr reset", 8'h10, 32'h0300_0000, '1);
    rchk("status reset", 8'h1c, 32'h0, '1);
    wreg(8'h00, 32'hdead_beff);
    wreg(8'h04, 32'h0000_00a5);
    wreg(8'h10, 32'hffff_ffff);
    wreg(8'h14, 32'hffff_ffff);
    wreg(8'h18, 32'hffff_ffff);
    rchk("next lo", 8'h00, 32'hdead_bec0, '1);
    rchk("attr", 8'h10, 32'hff00_0000, '1);
    rchk("stride", 8'h14, 32'hfff8_ffff, '1);
    rchk("length", 8'h18, 32'h0000_ffff, '1);
    rchk("unmapped", 8'h3c, 32'h0, '1);
    chk("next narrow", 64'hdead_bec0, nda);
    wreg(8'h28, 32'h2);
    rchk("ptr hi", 8'h24, 32'ha5, '1);
    chk("next wide", 64'h0000_00a5_dead_bec0, nda);
  endtask

  task automatic t_stride(input logic wide, input logic [15:0] len, input int lines,
    input logic [15:0] strd);
    int nb;
    logic [63:0] base;
    nb = (len + 3) / 4;
    base = wide ? 64'h5_0000_1000 : 64'h1000;
    wreg(8'h08, 32'h0000_1000);
    wreg(8'h0c, 32'h0000_0005);
    wreg(8'h10, 32'h9300_0000);
    wreg(8'h14, {lines[12:0], 3'h0, strd});
    wreg(8'h18, {16'h0, len});
    tdst <= 5'h15;
    tid <= 5'h0a;
    tus <= 4'h6;
    // Mode is latched on the same edge as start, so set it first
    wreg(8'h28, {30'h0, wide, 1'b0});
    wreg(8'h28, {30'h0, wide, 1'b1});
    send(nb * lines, nb * lines - 1);
    wait_idle();
    for (int l = 0; l < lines; l++)
      for (int b = 0; b < nb; b++)
      begin
        chk("awaddr", base + l * strd + b * 4, aq.pop_front());
        chk("awcache", 4'h3, cq.pop_front());
        chk("awuser", 4'h9, uq.pop_front());
        chk("wdata", 32'hc0de0000 + l * nb + b, dq.pop_front());
        chk("wstrb", (b == nb - 1 && len[1:0] != 2'h0) ? 4'hf >> (3'h4 - len[1:0]) : 4'hf,
          sq.pop_front());
      end
    chk("extra writes", 0, aq.size());
    rchk("status", 8'h1c, 32'h8c06_0a15, '1);
  endtask

  task automatic t_errors();
    aq.delete();
    err <= 1'b1;
    wreg(8'h14, 32'h000f_0010);
    wreg(8'h18, 32'hffff_0004);
    wreg(8'h28, 32'h1);
    send(1, 0);
    wait_idle();
    rchk("slave err", 8'h1c, 32'h2000_0000, 32'h3000_0000);
    rchk("halted", 8'h28, 32'h4, 32'h4);
    chk("one write", 1, aq.size());
    err <= 1'b0;
    wreg(8'h28, 32'h4);
    wreg(8'h18, 32'h8);
    wreg(8'h28, 32'h1);
    send(1, 0);
    wait_idle();
    rchk("early last", 8'h1c, 32'h1000_0000, 32'h3000_0000);
    wreg(8'h28, 32'h4);
    wreg(8'h14, 32'h0000_0010);
    wreg(8'h28, 32'h1);
    wait_idle();
    rchk("zero lines", 8'h1c, 32'h1000_0000, 32'h3000_0000);
    wreg(8'h28, 32'h4);
    rchk("resumed", 8'h28, 32'h0, 32'h4);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this allows ten thousand
  initial
  begin
    #400000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    {srst, wr, rd, tv, tl, slow, err} = 7'h40;
    {ra, wd, td, tdst, tid, tus} = '0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_stride(1'b0, 16'd6, 3, 16'h20);
    slow <= 1'b1;
    t_stride(1'b1, 16'd7, 2, 16'h40);
    slow <= 1'b0;
    t_stride(1'b0, 16'd5, 1, 16'h10);
    t_errors();
    chk("stall seen", 1, stalls != 0);
    wrap_up();
  end
endmodule

`default_nettype wire
